// >>> hdl/sdram_cfg_regs.vh
// register layout and command codes of the configuration word
`ifndef SDRAM_CFG_REGS_VH
`define SDRAM_CFG_REGS_VH
`define CFG_WIDTH        13
`define CFG_BL_LSB       0
`define CFG_BL_MSB       2
`define CFG_ORDER_BIT    3
`define CFG_LAT_LSB      4
`define CFG_LAT_MSB      6
`define CFG_OPM_LSB      7
`define CFG_OPM_MSB      8
`define CFG_WB_BIT       9
`define CFG_RESET        13'h0000
// command code {cs_n, ras_n, cas_n, we_n}
`define CMD_LOAD_CFG     4'h0
// burst length codes
`define BL_1             3'h0
`define BL_2             3'h1
`define BL_4             3'h2
`define BL_8             3'h3
`define BL_PAGE          3'h7
// read latency codes
`define LAT_2            3'h2
`define LAT_3            3'h3
// full page burst length in locations, fixed here
`define PAGE_LEN         10'h200
`endif

// >>> hdl/cfg_decode.v
// decode of the configuration word into burst and latency settings
`timescale 1ns/1ps
`default_nettype none
`include "sdram_cfg_regs.vh"
module cfg_decode
(
   // configuration word
   input  wire [12:0] word_i,
   // decoded settings
   output reg  [9:0]  burst_len_o,
   output reg         burst_term_o,
   output reg  [1:0]  latency_o,
   output reg         cfg_valid_o
);
   reg lat_ok;
   reg bl_ok;
   always @*
   begin
      burst_term_o = 1'b0;
      bl_ok        = 1'b1;
      case (word_i[`CFG_BL_MSB:`CFG_BL_LSB])
         `BL_1:   burst_len_o = 10'h001;
         `BL_2:   burst_len_o = 10'h002;
         `BL_4:   burst_len_o = 10'h004;
         `BL_8:   burst_len_o = 10'h008;
         `BL_PAGE:
         begin
            // full page runs until a terminate; only sequential order
            burst_len_o  = `PAGE_LEN;
            burst_term_o = 1'b1;
            bl_ok        = ~word_i[`CFG_ORDER_BIT];
         end
         default:
         begin
            burst_len_o = 10'h001;
            bl_ok       = 1'b0;
         end
      endcase
      case (word_i[`CFG_LAT_MSB:`CFG_LAT_LSB])
         `LAT_2:
         begin
            latency_o = 2'h2;
            lat_ok    = 1'b1;
         end
         `LAT_3:
         begin
            latency_o = 2'h3;
            lat_ok    = 1'b1;
         end
         default:
         begin
            latency_o = 2'h3;
            lat_ok    = 1'b0;
         end
      endcase
      cfg_valid_o = bl_ok & lat_ok
                  & (word_i[`CFG_OPM_MSB:`CFG_OPM_LSB] == 2'h0);
   end
endmodule
`default_nettype wire

// >>> hdl/sdram_cfg_reg.v
// configuration register of the synchronous dram and its decoded fields
`timescale 1ns/1ps
`default_nettype none
`include "sdram_cfg_regs.vh"
module sdram_cfg_reg
(
   // clock and reset
   input  wire        REF_CLK_I,
   input  wire        RST_I,
   // command pins, active low, then bank and address pins
   input  wire        CS_N_I,
   input  wire        RAS_N_I,
   input  wire        CAS_N_I,
   input  wire        WE_N_I,
   input  wire [1:0]  BANK_I,
   input  wire [12:0] ADDR_I,
   // stored word and decoded settings
   output reg  [12:0] CFG_WORD_O,
   output reg  [9:0]  BURST_LEN_O,
   output reg         BURST_ORDER_O,
   output reg         BURST_TERM_O,
   output reg  [1:0]  READ_LATENCY_O,
   output reg  [1:0]  OP_MODE_O,
   output reg         WRITE_SINGLE_O,
   output reg         CFG_VALID_O,
   output reg         CFG_LOADED_O,
   output reg         LOAD_PULSE_O
);
   // -----------------------------------------------------------------
   // command decode
   // -----------------------------------------------------------------
   wire load_cmd;
   assign load_cmd = ({CS_N_I, RAS_N_I, CAS_N_I, WE_N_I} == `CMD_LOAD_CFG)
                   & (BANK_I == 2'h0);

   // -----------------------------------------------------------------
   // configuration word
   // -----------------------------------------------------------------
   reg  [12:0] operating_config_word_q;
   wire [12:0] operating_config_word_d;
   reg         loaded_q;
   assign operating_config_word_d = load_cmd ? ADDR_I
                                             : operating_config_word_q;
   always @(posedge REF_CLK_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         operating_config_word_q <= `CFG_RESET;
         loaded_q                <= 1'b0;
      end
      else
      begin
         operating_config_word_q <= operating_config_word_d;
         loaded_q                <= loaded_q | load_cmd;
      end
   end

   // -----------------------------------------------------------------
   // field decode, registered so outputs come from flip-flops
   // -----------------------------------------------------------------
   wire [9:0] bl_w;
   wire       term_w;
   wire [1:0] lat_w;
   wire       valid_w;
   cfg_decode u_decode
   (
      .word_i       (operating_config_word_d),
      .burst_len_o  (bl_w),
      .burst_term_o (term_w),
      .latency_o    (lat_w),
      .cfg_valid_o  (valid_w)
   );

   // -----------------------------------------------------------------
   // stored word
   // -----------------------------------------------------------------
   // reserved bits stored only
   always @(posedge REF_CLK_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         CFG_WORD_O <= `CFG_RESET;
      end
      else
      begin
         CFG_WORD_O <= operating_config_word_d;
      end
   end

   // -----------------------------------------------------------------
   // burst length
   // -----------------------------------------------------------------
   // burst length field
   always @(posedge REF_CLK_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         BURST_LEN_O <= 10'h001;
      end
      else
      begin
         BURST_LEN_O <= bl_w;
      end
   end

   // -----------------------------------------------------------------
   // burst terminate need
   // -----------------------------------------------------------------
   // full page terminate
   always @(posedge REF_CLK_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         BURST_TERM_O <= 1'b0;
      end
      else
      begin
         BURST_TERM_O <= term_w;
      end
   end

   // -----------------------------------------------------------------
   // burst order
   // -----------------------------------------------------------------
   // order bit
   always @(posedge REF_CLK_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         BURST_ORDER_O <= 1'b0;
      end
      else
      begin
         BURST_ORDER_O <= operating_config_word_d[`CFG_ORDER_BIT];
      end
   end

   // -----------------------------------------------------------------
   // read latency
   // -----------------------------------------------------------------
   // latency field
   always @(posedge REF_CLK_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         READ_LATENCY_O <= 2'h3;
      end
      else
      begin
         READ_LATENCY_O <= lat_w;
      end
   end

   // -----------------------------------------------------------------
   // operating mode
   // -----------------------------------------------------------------
   // operating mode field
   always @(posedge REF_CLK_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         OP_MODE_O <= 2'h0;
      end
      else
      begin
         OP_MODE_O <= operating_config_word_d[`CFG_OPM_MSB:`CFG_OPM_LSB];
      end
   end

   // -----------------------------------------------------------------
   // write burst behaviour
   // -----------------------------------------------------------------
   // write burst bit
   always @(posedge REF_CLK_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         WRITE_SINGLE_O <= 1'b0;
      end
      else
      begin
         WRITE_SINGLE_O <= operating_config_word_d[`CFG_WB_BIT];
      end
   end

   // -----------------------------------------------------------------
   // validity
   // -----------------------------------------------------------------
   // invalid until loaded
   always @(posedge REF_CLK_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         CFG_VALID_O <= 1'b0;
      end
      else
      begin
         CFG_VALID_O <= valid_w & (loaded_q | load_cmd);
      end
   end

   // -----------------------------------------------------------------
   // loaded flag
   // -----------------------------------------------------------------
   // sticky so a controller can see that initialisation happened
   always @(posedge REF_CLK_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         CFG_LOADED_O <= 1'b0;
      end
      else
      begin
         CFG_LOADED_O <= loaded_q | load_cmd;
      end
   end

   // -----------------------------------------------------------------
   // load pulse
   // -----------------------------------------------------------------
   // one cycle per load
   always @(posedge REF_CLK_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         LOAD_PULSE_O <= 1'b0;
      end
      else
      begin
         LOAD_PULSE_O <= load_cmd;
      end
   end
endmodule
`default_nettype wire

// >>> testbench/cfg_ctrl_model.sv
// controller model that issues commands to the configuration register
`timescale 1ns/1ps
`default_nettype none
module cfg_ctrl_model
(
   input  wire logic        clk_i,
   output logic      [3:0]  cmd_n_o,
   output logic      [1:0]  bank_o,
   output logic      [12:0] addr_o
);
   initial
   begin
      cmd_n_o = 4'hF;
      bank_o = 2'h3;
      addr_o = 13'h1FFF;
   end
   task automatic issue(input logic [3:0] c, input logic [1:0] b,
                        input logic [12:0] a);
   begin
      @(posedge clk_i);
      #1 cmd_n_o = c;
      bank_o = b;
      addr_o = a;
      @(posedge clk_i);
      // released pins must not keep showing the old value
      #1 cmd_n_o = 4'hF;
      bank_o = ~b;
      addr_o = ~a;
   end
   endtask
endmodule
`default_nettype wire

// >>> testbench/cfg_reg_chk.sv
// assertions on the configuration register ports
`timescale 1ns/1ps
`default_nettype none
module cfg_reg_chk
(
   input wire logic        REF_CLK_I, RST_I, CS_N_I, RAS_N_I, CAS_N_I,
   input wire logic        WE_N_I, BURST_ORDER_O, WRITE_SINGLE_O,
   input wire logic        LOAD_PULSE_O,
   input wire logic [1:0]  BANK_I, READ_LATENCY_O, OP_MODE_O,
   input wire logic [12:0] ADDR_I, CFG_WORD_O,
   input wire logic [9:0]  BURST_LEN_O
);
   wire ld = !(CS_N_I | RAS_N_I | CAS_N_I | WE_N_I) && BANK_I == 2'h0;
   default clocking @(posedge REF_CLK_I); endclocking
   default disable iff (RST_I);
   word_load_a: assert property (ld |=> CFG_WORD_O == $past(ADDR_I))
      else $error("word not loaded");
   word_hold_a: assert property (!ld |=> $stable(CFG_WORD_O))
      else $error("word changed");
   load_pulse_a: assert property (LOAD_PULSE_O == $past(ld))
      else $error("bad load pulse");
   burst_order_a: assert property (BURST_ORDER_O == CFG_WORD_O[3])
      else $error("bad order");
   write_mode_a: assert property (WRITE_SINGLE_O == CFG_WORD_O[9])
      else $error("bad write mode");
   op_mode_a: assert property (OP_MODE_O == CFG_WORD_O[8:7])
      else $error("bad mode");
   latency_two_a: assert property
      (CFG_WORD_O[6:4] == 3'h2 |-> READ_LATENCY_O == 2'h2)
      else $error("bad latency");
   burst_eight_a: assert property
      (CFG_WORD_O[2:0] == 3'h3 |-> BURST_LEN_O == 10'h008)
      else $error("bad length");
   latency_legal_a: assert property (READ_LATENCY_O >= 2'h2)
      else $error("latency out of range");
endmodule
bind sdram_cfg_reg cfg_reg_chk cfg_reg_chk_i (.*);
`default_nettype wire

// >>> testbench/testbench.sv
// self-checking bench for the configuration register
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clk = 1'b0;
   logic rst = 1'b1;
   int mismatches = 0;
   int comparisons = 0;
   int cycles = 0;
   wire [3:0] cmd_n;
   wire [1:0] bank, lat, mode;
   wire [12:0] addr, word;
   wire [9:0] blen;
   wire order, term, ws, valid, loaded, pulse;
   always #5 clk = ~clk;
   cfg_ctrl_model cfg_ctrl_model_i (.clk_i(clk), .cmd_n_o(cmd_n),
      .bank_o(bank), .addr_o(addr));
   sdram_cfg_reg sdram_cfg_reg_i (.REF_CLK_I(clk), .RST_I(rst),
      .CS_N_I(cmd_n[3]), .RAS_N_I(cmd_n[2]), .CAS_N_I(cmd_n[1]),
      .WE_N_I(cmd_n[0]), .BANK_I(bank), .ADDR_I(addr), .CFG_WORD_O(word),
      .BURST_LEN_O(blen), .BURST_ORDER_O(order), .BURST_TERM_O(term),
      .READ_LATENCY_O(lat), .OP_MODE_O(mode), .WRITE_SINGLE_O(ws),
      .CFG_VALID_O(valid), .CFG_LOADED_O(loaded), .LOAD_PULSE_O(pulse));
   task automatic check(input logic [12:0] s, e, input string m);
   begin
      comparisons++;
      if (s !== e)
      begin
         mismatches++;
         $display("CHECK FAILED %0t %s", $time, m);
      end
   end
   endtask
   task finish_test;
   begin
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   end
   endtask
   task t_len;
      logic [2:0] c [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
      logic [9:0] n [5] = '{10'h001, 10'h002, 10'h004, 10'h008, 10'h200};
   begin
      check(13'(blen), 13'h0001, "reset length");
      check(13'(loaded), 13'h0000, "reset loaded");
      for (int i = 0; i < 5; i++)
      begin
         cfg_ctrl_model_i.issue(4'h0, 2'h0, {6'h00, 3'h3, 1'b0, c[i]});
         check(13'(blen), 13'(n[i]), "length");
         check(13'(term), 13'(c[i] == 3'h7), "terminate");
         check(13'(valid), 13'h0001, "valid");
         check(13'(pulse), 13'h0001, "pulse");
      end
      $display("test length done");
   end
   endtask
   task t_fields;
   begin
      cfg_ctrl_model_i.issue(4'h0, 2'h0, 13'h1E2A);
      check(word, 13'h1E2A, "word");
      check(13'(order), 13'h0001, "order");
      check(13'(lat), 13'h0002, "latency");
      check(13'(ws), 13'h0001, "write mode");
      check(13'(valid), 13'h0001, "valid");
      cfg_ctrl_model_i.issue(4'h0, 2'h0, 13'h01B0);
      check(13'(mode), 13'h0003, "mode");
      check(13'(lat), 13'h0003, "latency");
      check(13'(valid), 13'h0000, "mode invalid");
      $display("test fields done");
   end
   endtask
   task t_refuse;
   begin
      cfg_ctrl_model_i.issue(4'h1, 2'h0, 13'h0FFF);
      check(13'(pulse), 13'h0000, "pulse");
      cfg_ctrl_model_i.issue(4'h0, 2'h1, 13'h0FFF);
      check(word, 13'h01B0, "word held");
      check(13'(loaded), 13'h0001, "loaded");
      $display("test refuse done");
   end
   endtask
   task t_illegal;
   begin
      cfg_ctrl_model_i.issue(4'h0, 2'h0, 13'h0014);
      check(13'(blen), 13'h0001, "bad length code");
      check(13'(lat), 13'h0003, "bad latency code");
      check(13'(valid), 13'h0000, "bad codes invalid");
      cfg_ctrl_model_i.issue(4'h0, 2'h0, 13'h003F);
      check(13'(blen), 13'h0200, "page length");
      check(13'(term), 13'h0001, "page terminate");
      check(13'(valid), 13'h0000, "page interleaved");
      $display("test illegal done");
   end
   endtask
   initial
   begin
      repeat (2) @(posedge clk);
      #1 rst = 1'b0;
      t_len;
      t_fields;
      t_refuse;
      t_illegal;
      finish_test;
   end
   // a hang would otherwise run forever
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 500)
      begin
         mismatches++;
         finish_test;
      end
   end
endmodule
`default_nettype wire
